// ---- hdl/serdes_link_status_regs.v ----
// Clear-on-read link and alignment status bank for two transceiver quads
//
// Summary of operation
// [RULE1] Status registers read-only, cleared by reading
// [RULE2] Link state codes 00, 10, 01
// [RULE3] C field bits 4:5, D field 6:7
// [RULE4] Word aligned bit set on alignment
// [RULE5] Lane aligned bit set on alignment
// [RULE6] Twin FIFO overflow flag per quad
// [RULE7] Twin sync failed flag per quad
// [RULE8] Select control enables link state machine
// [RULE9] Software uses 18-bit system address
// [RULE10] Event during clearing read stays latched
`timescale 1ns/1ps
`include "serdes_link_status_regs.vh"
module serdes_link_status_regs (
  input wire CLK,
  input wire RST_N,
  input wire CE,
  // System bus slave
  input wire [`ADDR_W-1:0] SYS_ADDR,
  input wire SYS_RD,
  input wire SYS_WR,
  input wire [`DATA_W-1:0] SYS_WDATA,
  output reg [`DATA_W-1:0] SYS_RDATA,
  output reg SYS_RDVALID,
  // Core status, index 0 is quad A, index 1 is quad B
  input wire [3:0] LINK_STATE_CH_C,
  input wire [3:0] LINK_STATE_CH_D,
  input wire [1:0] WORD_ALIGNED_CH_C,
  input wire [1:0] WORD_ALIGNED_CH_D,
  input wire [1:0] LANE_ALIGNED_CH_C,
  input wire [1:0] LANE_ALIGNED_CH_D,
  input wire [1:0] TWIN_FIFO_OVERFLOW,
  input wire [1:0] TWIN_SYNC_FAILED,
  // Link machine select toward the channel logic
  output reg [1:0] LINK_MACHINE_SELECT
);
  localparam RAW_W = 20;

  // ---------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------
  wire [RAW_W-1:0] raw_in;
  wire [RAW_W-1:0] sync_out;

  assign raw_in = {TWIN_SYNC_FAILED, TWIN_FIFO_OVERFLOW, LANE_ALIGNED_CH_D,
                   LANE_ALIGNED_CH_C, WORD_ALIGNED_CH_D, WORD_ALIGNED_CH_C,
                   LINK_STATE_CH_D, LINK_STATE_CH_C};

  status_sync #(
    .WIDTH(RAW_W)
  ) u_sync (
    .CLK(CLK),
    .RST_N(RST_N),
    .CE(CE),
    .D(raw_in),
    .Q(sync_out)
  );

  wire [3:0] link_c_s = sync_out[3:0];
  wire [3:0] link_d_s = sync_out[7:4];
  wire [1:0] word_c_s = sync_out[9:8];
  wire [1:0] word_d_s = sync_out[11:10];
  wire [1:0] lane_c_s = sync_out[13:12];
  wire [1:0] lane_d_s = sync_out[15:14];
  wire [1:0] ovfl_s = sync_out[17:16];
  wire [1:0] oos_s = sync_out[19:18];

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Sticky bit: a live event beats the clearing read
  function sticky;
    input cur;
    input event_in;
    input clr;
    begin
      sticky = event_in | (cur & ~clr); // [RULE10]
    end
  endfunction

  // Link field: latest meaningful code is held until read
  function [1:0] link_next;
    input [1:0] cur;
    input [1:0] code;
    input enable;
    input clr;
    begin
      if (enable && (code == `LINK_SYNC_DONE || code == `LINK_LOST_CV)) begin
        link_next = code; // [RULE2] [RULE10]
      end else if (clr) begin
        link_next = `LINK_NO_SYNC; // [RULE1]
      end else begin
        link_next = cur;
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire rd_link_a = SYS_RD && (SYS_ADDR == `QUAD_A_LINK_STATE_ADDR); // [RULE9]
  wire rd_link_b = SYS_RD && (SYS_ADDR == `QUAD_B_LINK_STATE_ADDR);
  wire rd_algn_a = SYS_RD && (SYS_ADDR == `QUAD_A_ALIGNMENT_STATE_ADDR);
  wire rd_algn_b = SYS_RD && (SYS_ADDR == `QUAD_B_ALIGNMENT_STATE_ADDR);
  wire rd_twin_a = SYS_RD && (SYS_ADDR == `QUAD_A_TWIN_SYNC_FLAGS_ADDR);
  wire rd_twin_b = SYS_RD && (SYS_ADDR == `QUAD_B_TWIN_SYNC_FLAGS_ADDR);
  wire [1:0] clr_link = {rd_link_b, rd_link_a};
  wire [1:0] clr_algn = {rd_algn_b, rd_algn_a};
  wire [1:0] clr_twin = {rd_twin_b, rd_twin_a};

  // ---------------------------------------------------------------
  // Status storage
  // ---------------------------------------------------------------
  reg [1:0] link_c_reg [0:1];
  reg [1:0] link_d_reg [0:1];
  reg [1:0] word_c_reg, word_d_reg, lane_c_reg, lane_d_reg, ovfl_reg, oos_reg;
  reg [1:0] word_c_next, word_d_next, lane_c_next, lane_d_next, ovfl_next, oos_next;
  reg [1:0] link_c_next [0:1];
  reg [1:0] link_d_next [0:1];
  integer q;
  integer r;

  always @* begin
    for (q = 0; q < 2; q = q + 1) begin
      link_c_next[q] = link_next(link_c_reg[q], link_c_s[2*q +: 2],
                                 LINK_MACHINE_SELECT[q], clr_link[q]); // [RULE8]
      link_d_next[q] = link_next(link_d_reg[q], link_d_s[2*q +: 2],
                                 LINK_MACHINE_SELECT[q], clr_link[q]); // [RULE8]
      word_c_next[q] = sticky(word_c_reg[q], word_c_s[q], clr_algn[q]); // [RULE4]
      word_d_next[q] = sticky(word_d_reg[q], word_d_s[q], clr_algn[q]); // [RULE4]
      lane_c_next[q] = sticky(lane_c_reg[q], lane_c_s[q], clr_algn[q]); // [RULE5]
      lane_d_next[q] = sticky(lane_d_reg[q], lane_d_s[q], clr_algn[q]); // [RULE5]
      ovfl_next[q] = sticky(ovfl_reg[q], ovfl_s[q], clr_twin[q]); // [RULE6]
      oos_next[q] = sticky(oos_reg[q], oos_s[q], clr_twin[q]); // [RULE7]
    end
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (r = 0; r < 2; r = r + 1) begin
        link_c_reg[r] <= `LINK_STATE_RESET; // [RULE3]
        link_d_reg[r] <= `LINK_STATE_RESET; // [RULE3]
      end
      word_c_reg <= 2'h0;
      word_d_reg <= 2'h0;
      lane_c_reg <= 2'h0;
      lane_d_reg <= 2'h0;
      ovfl_reg <= 2'h0;
      oos_reg <= 2'h0;
    end else if (CE) begin
      for (r = 0; r < 2; r = r + 1) begin
        link_c_reg[r] <= link_c_next[r];
        link_d_reg[r] <= link_d_next[r];
      end
      word_c_reg <= word_c_next;
      word_d_reg <= word_d_next;
      lane_c_reg <= lane_c_next;
      lane_d_reg <= lane_d_next;
      ovfl_reg <= ovfl_next;
      oos_reg <= oos_next;
    end
  end

  // ---------------------------------------------------------------
  // Control register: only the select bit is implemented
  // ---------------------------------------------------------------
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      LINK_MACHINE_SELECT <= 2'h0; // [RULE8]
    end else if (CE && SYS_WR) begin
      if (SYS_ADDR == `QUAD_A_LINK_CTRL_ADDR) begin
        LINK_MACHINE_SELECT[0] <= SYS_WDATA[`LINK_MACHINE_SELECT_BIT]; // [RULE8]
      end
      if (SYS_ADDR == `QUAD_B_LINK_CTRL_ADDR) begin
        LINK_MACHINE_SELECT[1] <= SYS_WDATA[`LINK_MACHINE_SELECT_BIT]; // [RULE8]
      end
    end
  end

  // ---------------------------------------------------------------
  // Read data assembly
  // ---------------------------------------------------------------
  reg [`DATA_W-1:0] rdata_next;

  always @* begin
    rdata_next = `STATUS_RESET;
    case (SYS_ADDR)
      `QUAD_A_LINK_STATE_ADDR, `QUAD_B_LINK_STATE_ADDR: begin
        // Address bit 8 tells quad B from quad A
        rdata_next[`LINK_STATE_C_HI_BIT] = link_c_reg[SYS_ADDR[8]][1]; // [RULE3]
        rdata_next[`LINK_STATE_C_LO_BIT] = link_c_reg[SYS_ADDR[8]][0]; // [RULE3]
        rdata_next[`LINK_STATE_D_HI_BIT] = link_d_reg[SYS_ADDR[8]][1]; // [RULE3]
        rdata_next[`LINK_STATE_D_LO_BIT] = link_d_reg[SYS_ADDR[8]][0]; // [RULE3]
      end
      `QUAD_A_ALIGNMENT_STATE_ADDR: begin
        rdata_next[`WORD_ALIGNED_C_BIT] = word_c_reg[0];
        rdata_next[`WORD_ALIGNED_D_BIT] = word_d_reg[0];
        rdata_next[`LANE_ALIGNED_C_BIT] = lane_c_reg[0];
        rdata_next[`LANE_ALIGNED_D_BIT] = lane_d_reg[0];
      end
      `QUAD_B_ALIGNMENT_STATE_ADDR: begin
        rdata_next[`WORD_ALIGNED_C_BIT] = word_c_reg[1];
        rdata_next[`WORD_ALIGNED_D_BIT] = word_d_reg[1];
        rdata_next[`LANE_ALIGNED_C_BIT] = lane_c_reg[1];
        rdata_next[`LANE_ALIGNED_D_BIT] = lane_d_reg[1];
      end
      `QUAD_A_TWIN_SYNC_FLAGS_ADDR: begin
        rdata_next[`TWIN_FIFO_OVERFLOW_BIT] = ovfl_reg[0];
        rdata_next[`TWIN_SYNC_FAILED_BIT] = oos_reg[0];
      end
      `QUAD_B_TWIN_SYNC_FLAGS_ADDR: begin
        rdata_next[`TWIN_FIFO_OVERFLOW_BIT] = ovfl_reg[1];
        rdata_next[`TWIN_SYNC_FAILED_BIT] = oos_reg[1];
      end
      `QUAD_A_LINK_CTRL_ADDR: begin
        rdata_next[`LINK_MACHINE_SELECT_BIT] = LINK_MACHINE_SELECT[0];
      end
      `QUAD_B_LINK_CTRL_ADDR: begin
        rdata_next[`LINK_MACHINE_SELECT_BIT] = LINK_MACHINE_SELECT[1];
      end
      default: begin
        rdata_next = `STATUS_RESET;
      end
    endcase
  end

  // Writes to status addresses are ignored, which keeps them read-only
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      SYS_RDATA <= `STATUS_RESET;
      SYS_RDVALID <= 1'b0;
    end else if (CE) begin
      SYS_RDVALID <= SYS_RD;
      if (SYS_RD) begin
        SYS_RDATA <= rdata_next; // [RULE1]
      end
    end
  end
endmodule

// ---- hdl/serdes_link_status_regs.vh ----
// Address map, field positions, reset values and codes of the link status bank
`ifndef SERDES_LINK_STATUS_REGS_VH
`define SERDES_LINK_STATUS_REGS_VH

`define ADDR_W 18
`define DATA_W 8

`define QUAD_A_LINK_STATE_ADDR 18'h30804
`define QUAD_A_ALIGNMENT_STATE_ADDR 18'h30805
`define QUAD_A_TWIN_SYNC_FLAGS_ADDR 18'h30814
`define QUAD_A_LINK_CTRL_ADDR 18'h30820
`define QUAD_B_LINK_STATE_ADDR 18'h30904
`define QUAD_B_ALIGNMENT_STATE_ADDR 18'h30905
`define QUAD_B_TWIN_SYNC_FLAGS_ADDR 18'h30914
`define QUAD_B_LINK_CTRL_ADDR 18'h30920
`define RESERVED_SPARE_ADDR 18'h30933

// Bit numbers follow the byte's own 0..7 numbering; bit n sits on data line n
`define LINK_STATE_C_HI_BIT 4
`define LINK_STATE_C_LO_BIT 5
`define LINK_STATE_D_HI_BIT 6
`define LINK_STATE_D_LO_BIT 7
`define WORD_ALIGNED_C_BIT 2
`define WORD_ALIGNED_D_BIT 3
`define LANE_ALIGNED_C_BIT 6
`define LANE_ALIGNED_D_BIT 7
`define TWIN_FIFO_OVERFLOW_BIT 1
`define TWIN_SYNC_FAILED_BIT 4
`define LINK_MACHINE_SELECT_BIT 7

`define STATUS_RESET 8'h00
`define LINK_STATE_RESET 2'h0

// Link state codes, first printed digit is the upper bit
`define LINK_NO_SYNC 2'h0
`define LINK_SYNC_DONE 2'h2
`define LINK_LOST_CV 2'h1
`define LINK_UNUSED 2'h3

`define SYNC_STAGES 2

`endif

// ---- hdl/status_sync.v ----
// Two-stage synchroniser for a bus of independent status levels
`timescale 1ns/1ps
module status_sync #(
  parameter WIDTH = 20
) (
  input wire CLK,
  input wire RST_N,
  input wire CE,
  input wire [WIDTH-1:0] D,
  output reg [WIDTH-1:0] Q
);
  reg [WIDTH-1:0] meta_reg;

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      meta_reg <= {WIDTH{1'b0}};
      Q <= {WIDTH{1'b0}};
    end else if (CE) begin
      meta_reg <= D;
      Q <= meta_reg;
    end
  end
endmodule

// ---- verification/serdes_link_status_regs_bench.sv ----
// Self-checking bench for the link status bank
`timescale 1ns/1ps
module serdes_link_status_regs_bench;
  reg CLK = 1'b0;
  reg RST_N = 1'b0;
  reg CE = 1'b1;
  reg [17:0] SYS_ADDR = 18'h0;
  reg SYS_RD = 1'b0;
  reg SYS_WR = 1'b0;
  reg [7:0] SYS_WDATA = 8'h00;
  reg [19:0] stim = 20'h0;
  wire [7:0] SYS_RDATA;
  wire SYS_RDVALID;
  wire [1:0] LINK_MACHINE_SELECT;
  logic [45:0] rows [0:7];
  integer fail_count = 0;
  integer n_checks = 0;
  integer i;
  always #5 CLK = ~CLK;
  serdes_link_status_regs serdes_link_status_regs_inst (
    .CLK(CLK), .RST_N(RST_N), .CE(CE), .SYS_ADDR(SYS_ADDR), .SYS_RD(SYS_RD), .SYS_WR(SYS_WR),
    .SYS_WDATA(SYS_WDATA), .SYS_RDATA(SYS_RDATA), .SYS_RDVALID(SYS_RDVALID),
    .LINK_STATE_CH_C(stim[19:16]), .LINK_STATE_CH_D(stim[15:12]),
    .WORD_ALIGNED_CH_C(stim[11:10]), .WORD_ALIGNED_CH_D(stim[9:8]),
    .LANE_ALIGNED_CH_C(stim[7:6]), .LANE_ALIGNED_CH_D(stim[5:4]),
    .TWIN_FIFO_OVERFLOW(stim[3:2]), .TWIN_SYNC_FAILED(stim[1:0]),
    .LINK_MACHINE_SELECT(LINK_MACHINE_SELECT));
  // ----------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------
  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task results;
    if (fail_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task rd(input logic [17:0] a, input logic [7:0] exp);
    @(posedge CLK);
    SYS_ADDR <= a;
    SYS_RD <= 1'b1;
    @(posedge CLK);
    SYS_RD <= 1'b0;
    #1;
    check("rdvalid", {7'h0, SYS_RDVALID}, 8'h01);
    check("rdata", SYS_RDATA, exp);
  endtask
  task wr(input logic [17:0] a, input logic [7:0] d);
    @(posedge CLK);
    SYS_ADDR <= a;
    SYS_WDATA <= d;
    SYS_WR <= 1'b1;
    @(posedge CLK);
    SYS_WR <= 1'b0;
  endtask
  // Core status settles through the synchroniser before it is read
  task settle(input logic [19:0] s);
    @(posedge CLK);
    stim <= s;
    repeat (5) @(posedge CLK);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rows[0] = {18'h30804, 20'h21000, 8'h90};
    rows[1] = {18'h30904, 20'h48000, 8'h60};
    rows[2] = {18'h30805, 20'h00550, 8'hcc};
    rows[3] = {18'h30905, 20'h00820, 8'h84};
    rows[4] = {18'h30814, 20'h00005, 8'h12};
    rows[5] = {18'h30914, 20'h00002, 8'h10};
    rows[6] = {18'h30933, 20'hfffff, 8'h00};
    rows[7] = {18'h30a00, 20'h00000, 8'h00};
    repeat (10) @(posedge CLK);
    RST_N <= 1'b1;
    for (i = 0; i < 8; i = i + 1)
      rd(rows[i][45:28], 8'h00);
    check("select", {6'h0, LINK_MACHINE_SELECT}, 8'h00);
    wr(18'h30820, 8'h80);
    wr(18'h30920, 8'h80);
    rd(18'h30920, 8'h80);
    check("select", {6'h0, LINK_MACHINE_SELECT}, 8'h03);
    for (i = 0; i < 8; i = i + 1) begin
      settle(rows[i][27:8]);
      rd(rows[i][45:28], rows[i][7:0]);
      settle(20'h0);
      rd(rows[i][45:28], rows[i][7:0]);
      rd(rows[i][45:28], 8'h00);
    end
    // Flags of both quads are still latched from the all-ones row
    rd(18'h30805, 8'hcc);
    rd(18'h30905, 8'hcc);
    rd(18'h30814, 8'h12);
    rd(18'h30914, 8'h12);
    wr(18'h30805, 8'hff);
    rd(18'h30805, 8'h00);
    wr(18'h30820, 8'h7f);
    rd(18'h30820, 8'h00);
    check("select", {6'h0, LINK_MACHINE_SELECT}, 8'h02);
    settle(20'ha0000);
    rd(18'h30804, 8'h00);
    rd(18'h30904, 8'h10);
    // Reset in mid-run clears latched status, read data and the select control
    settle(20'hfffff);
    settle(20'h0);
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    check("reset select", {6'h0, LINK_MACHINE_SELECT}, 8'h00);
    check("reset rdata", SYS_RDATA, 8'h00);
    RST_N <= 1'b1;
    rd(18'h30905, 8'h00);
    rd(18'h30914, 8'h00);
    rd(18'h30904, 8'h00);
    // Clock enable low freezes the bus, the control and the synchronisers
    @(posedge CLK);
    CE <= 1'b0;
    stim <= 20'h0000c;
    SYS_ADDR <= 18'h30820;
    SYS_WDATA <= 8'h80;
    SYS_WR <= 1'b1;
    SYS_RD <= 1'b1;
    repeat (6) @(posedge CLK);
    check("frozen rdvalid", {7'h0, SYS_RDVALID}, 8'h00);
    check("frozen select", {6'h0, LINK_MACHINE_SELECT}, 8'h00);
    SYS_RD <= 1'b0;
    SYS_WR <= 1'b0;
    stim <= 20'h0;
    CE <= 1'b1;
    rd(18'h30814, 8'h00);
    results;
  end
  initial begin
    #100000;
    fail_count = fail_count + 1;
    results;
  end
endmodule

// ---- verification/serdes_link_status_regs_props.sv ----
// Concurrent checks on the link status bank ports
`timescale 1ns/1ps
module serdes_link_status_regs_props (
  input wire CLK,
  input wire RST_N,
  input wire CE,
  input wire [17:0] SYS_ADDR,
  input wire SYS_RD,
  input wire SYS_WR,
  input wire [7:0] SYS_WDATA,
  input wire [7:0] SYS_RDATA,
  input wire SYS_RDVALID,
  input wire [1:0] TWIN_FIFO_OVERFLOW,
  input wire [1:0] LINK_MACHINE_SELECT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire rd = CE && SYS_RD;
  a_rd_answer: assert property (rd |=> SYS_RDVALID) else $error("no read answer");
  // A frozen clock enable holds the answer flag as it was
  a_rd_only: assert property (
    SYS_RDVALID |-> $past(rd) || $past(!CE && SYS_RDVALID)) else $error("stray answer");
  a_sel_write: assert property (CE && SYS_WR && SYS_ADDR == 18'h30820 |=>
    LINK_MACHINE_SELECT[0] == $past(SYS_WDATA[7])) else $error("select not written");
  a_sel_hold: assert property (!(CE && SYS_WR) |=> $stable(LINK_MACHINE_SELECT))
    else $error("select moved");
  a_spare_zero: assert property (SYS_RDVALID && $past(SYS_ADDR) == 18'h30933 |->
    SYS_RDATA == 8'h00) else $error("spare not zero");
  a_link_low: assert property (SYS_RDVALID && $past(SYS_ADDR[7:0]) == 8'h04 |->
    SYS_RDATA[3:0] == 4'h0) else $error("link low bits set");
  a_align_gaps: assert property (
    SYS_RDVALID && $past(SYS_ADDR[7:0]) == 8'h05 |-> (SYS_RDATA & 8'h33) == 8'h00)
    else $error("align gap bits set");
  a_twin_gaps: assert property (
    SYS_RDVALID && $past(SYS_ADDR[7:0]) == 8'h14 |-> (SYS_RDATA & 8'hed) == 8'h00)
    else $error("twin gap bits set");
  a_ovf_sticky: assert property ((CE && TWIN_FIFO_OVERFLOW[0]) [*4] ##0
    (SYS_RD && SYS_ADDR == 18'h30814) |=> SYS_RDATA[1]) else $error("overflow lost");
endmodule
bind serdes_link_status_regs serdes_link_status_regs_props serdes_link_status_regs_props_inst (
  .CLK(CLK), .RST_N(RST_N), .CE(CE), .SYS_ADDR(SYS_ADDR), .SYS_RD(SYS_RD), .SYS_WR(SYS_WR),
  .SYS_WDATA(SYS_WDATA), .SYS_RDATA(SYS_RDATA), .SYS_RDVALID(SYS_RDVALID),
  .TWIN_FIFO_OVERFLOW(TWIN_FIFO_OVERFLOW), .LINK_MACHINE_SELECT(LINK_MACHINE_SELECT));
